// [dv/pwr_ctl_sva.sv]
// Purpose: port-level checks for the sleep/suspend wake-up control
// Assumes: single mclk domain, sync srst
// Notes:   flags are internal; refusal is judged by the bench
`timescale 1ns/1ps
module pwr_ctl_sva
   import power_unit_pkg::*;
(
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       rst_pin_n,
   input wire logic       sleep_rail_float,
   input wire logic       idle_wake_irq,
   input wire logic       core_regulator_off,
   input wire logic       ram_on_battery,
   input wire logic       sys_clk_gate,
   input wire logic       pin_hold,
   input wire logic       analog_rail_tie,
   input wire logic       analog_rail_float,
   input wire logic       in_sleep,
   input wire logic       in_suspend,
   input wire logic       resume_core,
   input wire logic       idle_vector_req
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   property p_sleep_pwr; in_sleep |-> core_regulator_off && ram_on_battery && pin_hold; endproperty
   a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep power outputs wrong");
   property p_rail; in_sleep && $stable(sleep_rail_float) |->
      analog_rail_tie == !sleep_rail_float && analog_rail_float == sleep_rail_float; endproperty
   a_rail: assert property (p_rail) else $error("analog rail control wrong");
   property p_entry; $rose(in_sleep) |->
      $past(sfr_wr && sfr_addr == power_unit_config_addr && sfr_wdata[sleep_bit]); endproperty
   a_entry: assert property (p_entry) else $error("sleep without request");
   property p_susp; in_suspend |-> sys_clk_gate && !in_sleep; endproperty
   a_susp: assert property (p_susp) else $error("suspend clock not gated");
   property p_pin_wake; in_sleep && $fell(rst_pin_n) |-> ##[1:4] !in_sleep; endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("reset pin did not wake");
   property p_resume; $fell(in_sleep) |-> ##[0:2] resume_core; endproperty
   a_resume: assert property (p_resume) else $error("no resume after sleep");
   property p_rd_idle; !$past(sfr_rd) |-> sfr_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_rd_top; sfr_rdata[7:5] == 3'b000; endproperty
   a_rd_top: assert property (p_rd_top) else $error("write-only bits read back");
   property p_vec; idle_vector_req == $past(idle_wake_irq); endproperty
   a_vec: assert property (p_vec) else $error("idle vector request wrong");
endmodule : pwr_ctl_sva

bind sleep_suspend_wakeup_control pwr_ctl_sva u_sva (.mclk(mclk), .srst(srst), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .rst_pin_n(rst_pin_n), .sleep_rail_float(sleep_rail_float), .idle_wake_irq(idle_wake_irq),
   .core_regulator_off(core_regulator_off), .ram_on_battery(ram_on_battery),
   .sys_clk_gate(sys_clk_gate), .pin_hold(pin_hold), .analog_rail_tie(analog_rail_tie),
   .analog_rail_float(analog_rail_float), .in_sleep(in_sleep), .in_suspend(in_suspend),
   .resume_core(resume_core), .idle_vector_req(idle_vector_req));

// [dv/tb_top.sv]
// Purpose: self-checking bench for the sleep/suspend wake-up control
// Assumes: 100 MHz mclk, sync active-high srst
// Notes:   events pulse one cycle, since held levels re-set flags
`timescale 1ns/1ps
module tb_top
   import power_unit_pkg::*;
;
   // ------------------------------------------------------------
   // stimulus and checks
   // ------------------------------------------------------------
   logic       mclk = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, comp_out = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic       osc_fail_evt = 1'b0, alarm_evt = 1'b0, port_match_evt = 1'b0, rst_pin_n = 1'b1;
   logic       two_cell_mode = 1'b1, sleep_rail_float = 1'b0, idle_wake_irq = 1'b0;
   logic       core_regulator_off, ram_on_battery, sys_clk_gate, lp_osc_keep, pin_hold;
   logic       analog_rail_tie, analog_rail_float, in_sleep, in_suspend, resume_core, idle_vector_req;
   int         err_total = 0, total_checks = 0;
   localparam logic [7:0] a = power_unit_config_addr;

   sleep_suspend_wakeup_control DUT (.mclk(mclk), .srst(srst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .comp_out(comp_out),
      .osc_fail_evt(osc_fail_evt), .alarm_evt(alarm_evt), .port_match_evt(port_match_evt),
      .rst_pin_n(rst_pin_n), .two_cell_mode(two_cell_mode), .sleep_rail_float(sleep_rail_float),
      .idle_wake_irq(idle_wake_irq), .core_regulator_off(core_regulator_off), .pin_hold(pin_hold),
      .ram_on_battery(ram_on_battery), .sys_clk_gate(sys_clk_gate), .lp_osc_keep(lp_osc_keep),
      .analog_rail_tie(analog_rail_tie), .analog_rail_float(analog_rail_float),
      .in_sleep(in_sleep), .in_suspend(in_suspend), .resume_core(resume_core),
      .idle_vector_req(idle_vector_req));

   always #5 mclk = ~mclk;

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge mclk);
      sfr_wr <= 1'b1;
      sfr_addr <= ad;
      sfr_wdata <= d;
      @(posedge mclk);
      sfr_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] exp, input string what);
      @(posedge mclk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1;
      chk(what, exp, sfr_rdata);
   endtask : rd

   // m: osc fail, alarm, port match, reset pin low
   task automatic pulse(input logic [3:0] m);
      @(posedge mclk);
      {osc_fail_evt, alarm_evt, port_match_evt} <= m[3:1];
      rst_pin_n <= ~m[0];
      @(posedge mclk);
      {osc_fail_evt, alarm_evt, port_match_evt} <= 3'b000;
      rst_pin_n <= 1'b1;
      #1;
   endtask : pulse

   task automatic wait_resume(input string what);
      int n;
      n = 0;
      while (resume_core !== 1'b1 && n < 20)
      begin
         cyc(1);
         n++;
      end
      chk(what, 8'h01, 8'(resume_core));
      if (n >= 20)
         final_report();
   endtask : wait_resume

   task automatic t_sleep;
      chk("osc after reset", 8'h01, 8'(lp_osc_keep));
      rd(8'h00, "flags after reset");
      // bench software is taken to run undivided from the slow clock already
      wr(a, 8'hc4);
      cyc(1);
      chk("in_sleep", 8'h01, 8'(in_sleep));
      chk("regulator off", 8'h01, 8'(core_regulator_off));
      chk("sleep clock gate", 8'h01, 8'(sys_clk_gate));
      chk("osc released", 8'h00, 8'(lp_osc_keep));
      chk("in_suspend", 8'h00, 8'(in_suspend));
      chk("rail tie", 8'h01, 8'(analog_rail_tie));
      pulse(4'b0100);
      wait_resume("alarm wake");
      rd(8'h04, "alarm flag");
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_refuse;
      wr(a, 8'h88);
      cyc(2);
      chk("refused sleep", 8'h00, 8'(in_sleep));
      chk("osc kept", 8'h01, 8'(lp_osc_keep));
      wr(a, 8'h20);
      rd(8'h00, "flags cleared");
      wr(8'h00, 8'h84);
      idle_wake_irq <= 1'b1;
      cyc(2);
      chk("other address", 8'h00, 8'(in_sleep));
      chk("idle vector", 8'h01, 8'(idle_vector_req));
      idle_wake_irq <= 1'b0;
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_pin;
      @(posedge mclk);
      sleep_rail_float <= 1'b1;
      wr(a, 8'h82);
      cyc(1);
      chk("rail float", 8'h01, 8'(analog_rail_float));
      pulse(4'b1000);
      cyc(3);
      chk("disabled source", 8'h01, 8'(in_sleep));
      pulse(4'b0001);
      wait_resume("pin wake");
      rd(8'h18, "pin and fail flags");
      // stay awake long enough for a pin reset to act
      cyc(1500);
      wr(a, 8'h20);
      $display("test pin done");
   endtask : t_pin

   task automatic t_susp;
      two_cell_mode <= 1'b0;
      wr(a, 8'h41);
      comp_out <= 1'b1;
      cyc(4);
      chk("suspend gate", 8'h01, 8'(sys_clk_gate));
      chk("one-cell comparator", 8'h01, 8'(in_suspend));
      comp_out <= 1'b0;
      two_cell_mode <= 1'b1;
      cyc(1);
      comp_out <= 1'b1;
      wait_resume("comparator wake");
      // read sampled inside the two-clock window after suspend wake
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1;
      chk("blanked flags", 8'h00, sfr_rdata);
      cyc(3);
      rd(8'h01, "comparator flag");
      $display("test suspend done");
   endtask : t_susp

   initial
   begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      #1;
      t_sleep();
      t_refuse();
      t_pin();
      t_susp();
      final_report();
   end
endmodule : tb_top

// [rtl/power_unit_pkg.sv]
// Purpose: shared constants and types for the sleep/suspend wake-up control
// Assumes: 8-bit special-function register port, 100 MHz mclk
// Notes:   one register, the power unit configuration
package power_unit_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] power_unit_config_addr = 8'hb5;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int sleep_bit      = 7;
   localparam int suspend_bit    = 6;
   localparam int clear_bit      = 5;
   localparam int rst_flag_bit   = 4;
   localparam int osc_fail_bit   = 3;
   localparam int alarm_bit      = 2;
   localparam int port_match_bit = 1;
   localparam int comp_edge_bit  = 0;
   localparam int src_count      = 4;

   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [3:0] enable_reset     = 4'h0;
   localparam logic [4:0] flags_reset      = 5'h00;
   localparam int         wake_blank_clks  = 2;
   localparam logic [1:0] wake_blank_count = 2'(wake_blank_clks);
   localparam int         clk_period_ns    = 10;
   localparam int         regulator_settle_ns   = 20;
   localparam int         regulator_settle_clks =
      (regulator_settle_ns + clk_period_ns - 1) / clk_period_ns;
   localparam logic [3:0] settle_count = 4'(regulator_settle_clks);

   typedef enum {st_run, st_suspend, st_sleep, st_wake} power_state_t;

endpackage : power_unit_pkg

// [rtl/settle_timer.sv]
// Purpose: small down-counter that reports when a wait has elapsed
// Assumes: load pulse restarts the count
// Notes:   used for wake blanking after suspend
`timescale 1ns/1ps
module settle_timer
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       load,
   input  wire logic [3:0] count,
   output logic            busy
);

   typedef struct packed
   {
      logic [3:0] left;
   } timer_state_t;

   timer_state_t cur;
   timer_state_t next_cur;

   always_comb
   begin
      next_cur = cur;
      if (load)
      begin
         next_cur.left = count;
      end
      else if (cur.left != 4'h0)
      begin
         next_cur.left = cur.left - 4'h1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign busy = (cur.left != 4'h0);

endmodule : settle_timer

// [rtl/sleep_suspend_wakeup_control.sv]
// Purpose: sleep and suspend entry, wake-up sources and wake-up flags
// Assumes: sfr bus synchronous to mclk; events synchronous; rst_pin_n synchronised
// Notes:   power outputs are controls to regulator, ram switch and clock gate
//
// Behaviour
// - sleep bit 7 gates regulator, ram on battery
// - suspend bit 6 gates clock until wake
// - digital output pins held during sleep
// - analog rail tied to battery unless float bit
// - state preserved, execution resumes next instruction
// - comparator wake only in two-cell mode
// - reset pin falling edge always wakes
// - enables written with the entry request
// - flags update always, even when disabled
// - no entry, oscillator on, while flag set
// - clear bit 5 clears all flags, write-only
// - read-only reset-pin wake flag at bit 4
// - bits 3..0 enables on write, flags on read
// - idle wakes by vector, stop by reset source
// - flags read zero two clocks after suspend wake
`timescale 1ns/1ps
module sleep_suspend_wakeup_control
   import power_unit_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   output logic [7:0]      sfr_rdata,
   input  wire logic       osc_fail_evt,
   input  wire logic       alarm_evt,
   input  wire logic       port_match_evt,
   input  wire logic       comp_out,
   input  wire logic       rst_pin_n,
   input  wire logic       two_cell_mode,
   input  wire logic       sleep_rail_float,
   input  wire logic       idle_wake_irq,
   output logic            core_regulator_off,
   output logic            ram_on_battery,
   output logic            sys_clk_gate,
   output logic            lp_osc_keep,
   output logic            pin_hold,
   output logic            analog_rail_tie,
   output logic            analog_rail_float,
   output logic            in_sleep,
   output logic            in_suspend,
   output logic            resume_core,
   output logic            idle_vector_req
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      power_state_t mode;
      logic [3:0]   enable;
      logic [7:0]   rdata;
      logic         reg_off;
      logic         ram_bat;
      logic         clk_gate;
      logic         osc_keep;
      logic         hold;
      logic         rail_tie;
      logic         rail_float;
      logic         sleeping;
      logic         suspended;
      logic         resume;
      logic         idle_vec;
      logic         was_suspend;
   } ctl_state_t;

   ctl_state_t cur;
   ctl_state_t next_cur;

   logic [4:0] flags;
   logic       reg_hit;
   logic       clear_req;
   logic       blank_load;
   logic       blanking;
   logic       comp_gated;
   logic       any_flag;
   logic       wake_evt;

   assign reg_hit    = (sfr_addr == power_unit_config_addr);
   assign clear_req  = sfr_wr & reg_hit & sfr_wdata[clear_bit];
   // comparator is the only analog block alive in two-cell sleep
   assign comp_gated = comp_out & two_cell_mode;

   // ------------------------------------------------------------
   // wake-up flags
   // ------------------------------------------------------------
   // flags run every cycle regardless of enables or mode
   wake_flag u_flag_osc_fail (.mclk(mclk), .srst(srst), .event_in(osc_fail_evt),
      .rising_only(1'b0), .clear(clear_req), .flag(flags[osc_fail_bit]));
   wake_flag u_flag_alarm (.mclk(mclk), .srst(srst), .event_in(alarm_evt),
      .rising_only(1'b0), .clear(clear_req), .flag(flags[alarm_bit]));
   wake_flag u_flag_port (.mclk(mclk), .srst(srst), .event_in(port_match_evt),
      .rising_only(1'b0), .clear(clear_req), .flag(flags[port_match_bit]));
   wake_flag u_flag_comp (.mclk(mclk), .srst(srst), .event_in(comp_gated),
      .rising_only(1'b1), .clear(clear_req), .flag(flags[comp_edge_bit]));
   // falling edge of the pin, glitch or real reset alike
   wake_flag u_flag_rst (.mclk(mclk), .srst(srst), .event_in(~rst_pin_n),
      .rising_only(1'b1), .clear(clear_req), .flag(flags[rst_flag_bit]));

   // ------------------------------------------------------------
   // wake blanking after suspend
   // ------------------------------------------------------------
   settle_timer u_blank (
      .mclk  (mclk),
      .srst  (srst),
      .load  (blank_load),
      .count ({2'b00, wake_blank_count}),
      .busy  (blanking)
   );

   assign any_flag   = |flags;
   // reset pin needs no enable; other sources gated by their enable
   assign wake_evt   = flags[rst_flag_bit] | |(flags[3:0] & cur.enable);
   assign blank_load = (cur.mode == st_suspend) && wake_evt;

   // ------------------------------------------------------------
   // control
   // ------------------------------------------------------------
   always_comb
   begin
      logic [7:0] rd;
      rd       = 8'h00;
      next_cur = cur;
      next_cur.resume   = 1'b0;
      next_cur.idle_vec = idle_wake_irq;

      case (cur.mode)
         st_run:
         begin
            if (sfr_wr && reg_hit)
            begin
               next_cur.enable = sfr_wdata[3:0];
               // entry refused while a flag is pending
               if (!any_flag && sfr_wdata[sleep_bit])
               begin
                  next_cur.mode        = st_sleep;
                  next_cur.was_suspend = 1'b0;
               end
               else if (!any_flag && sfr_wdata[suspend_bit])
               begin
                  next_cur.mode        = st_suspend;
                  next_cur.was_suspend = 1'b1;
               end
            end
         end
         st_sleep, st_suspend:
         begin
            if (wake_evt)
            begin
               next_cur.mode = st_wake;
            end
         end
         st_wake:
         begin
            // registers untouched, core continues at next instruction
            next_cur.mode   = st_run;
            next_cur.resume = 1'b1;
         end
         default:
         begin
            next_cur.mode = st_run;
         end
      endcase

      next_cur.sleeping  = (next_cur.mode == st_sleep);
      next_cur.suspended = (next_cur.mode == st_suspend);
      next_cur.reg_off   = next_cur.sleeping;
      next_cur.ram_bat   = next_cur.sleeping;
      next_cur.clk_gate  = next_cur.sleeping | next_cur.suspended;
      next_cur.hold      = next_cur.sleeping;
      next_cur.rail_tie  = next_cur.sleeping & ~sleep_rail_float;
      next_cur.rail_float = next_cur.sleeping & sleep_rail_float;
      next_cur.osc_keep  = any_flag | (next_cur.mode == st_run);

      // control bits 7..5 read as zero; flags blanked just after suspend wake
      if (sfr_rd && reg_hit && !(cur.was_suspend && blanking))
      begin
         rd[4:0] = flags;
      end
      next_cur.rdata = rd;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         cur      <= '0;
         cur.mode <= st_run;
         cur.enable <= enable_reset;
         cur.osc_keep <= 1'b1;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign sfr_rdata          = cur.rdata;
   assign core_regulator_off = cur.reg_off;
   assign ram_on_battery     = cur.ram_bat;
   assign sys_clk_gate       = cur.clk_gate;
   assign lp_osc_keep        = cur.osc_keep;
   assign pin_hold           = cur.hold;
   assign analog_rail_tie    = cur.rail_tie;
   assign analog_rail_float  = cur.rail_float;
   assign in_sleep           = cur.sleeping;
   assign in_suspend         = cur.suspended;
   assign resume_core        = cur.resume;
   assign idle_vector_req    = cur.idle_vec;

endmodule : sleep_suspend_wakeup_control

// [rtl/wake_flag.sv]
// Purpose: one sticky wake-up flag with its event edge detector
// Assumes: event input synchronous to mclk
// Notes:   a set in the clear cycle wins
`timescale 1ns/1ps
module wake_flag
   import power_unit_pkg::*;
(
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic event_in,
   input  wire logic rising_only,
   input  wire logic clear,
   output logic      flag
);

   typedef struct packed
   {
      logic last;
      logic flag;
   } flag_state_t;

   flag_state_t cur;
   flag_state_t next_cur;

   always_comb
   begin
      logic hit;
      hit      = rising_only ? (event_in & ~cur.last) : event_in;
      next_cur = cur;
      next_cur.last = event_in;
      if (clear)
      begin
         next_cur.flag = 1'b0;
      end
      if (hit)
      begin
         next_cur.flag = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign flag = cur.flag;

endmodule : wake_flag
